// ---- rtl/xcvr_ctl_pkg.sv ----
package xcvr_ctl_pkg;

   // ------------------------------------------------------------
   // Three-level select codes
   // ------------------------------------------------------------
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] IRQ_ST_OFS  = 8'h08;
   localparam logic [7:0] IRQ_EN_OFS  = 8'h0c;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h10;

   // ------------------------------------------------------------
   // Control register fields and reset value
   // ------------------------------------------------------------
   localparam int CTRL_PAR_LSB   = 0;
   localparam int CTRL_RATE_LSB  = 2;
   localparam int CTRL_HALF_BIT  = 4;
   localparam int CTRL_TXM_LSB   = 5;
   localparam int CTRL_DEC_LSB   = 7;
   localparam int CTRL_TXCK_BIT  = 9;
   localparam int CTRL_RXCK_BIT  = 10;
   localparam int CTRL_W         = 11;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

   // ------------------------------------------------------------
   // Interrupt bits
   // ------------------------------------------------------------
   localparam int IRQ_PAR_ERR = 0;
   localparam int IRQ_INSERT  = 1;
   localparam int IRQ_DELETE  = 2;
   localparam int IRQ_BAD_CFG = 3;
   localparam int IRQ_W       = 4;
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

   // ------------------------------------------------------------
   // Framing character and timing
   // ------------------------------------------------------------
   localparam logic [9:0] K28_5_RAW    = 10'h0fa;
   localparam logic [7:0] K28_5_BYTE   = 8'hbc;
   localparam logic [2:0] K28_5_STATUS = 3'h1;
   localparam logic [3:0] SETTLE_CYCLES = 4'h8;

   // Serial rate ranges in MBaud per select level
   localparam int RATE_LOW_MIN  = 195;
   localparam int RATE_LOW_MAX  = 400;
   localparam int RATE_MID_MAX  = 800;
   localparam int RATE_HIGH_MAX = 1500;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/xcvr_dev_ctl.sv ----
`timescale 1ns/10ps
// How it works
// RULE1: Parity low: no check, parity output floats.
// RULE2: Mid, coded: odd parity over bytes only.
// RULE3: Mid, uncoded: add control and status bits.
// RULE4: High: add all control and status bits.
// RULE5: Rate select sets PLL range code.
// RULE6: Host avoids half-rate with low rate.
// RULE7: Device reset clears state, pointers to nominal.
// RULE8: Outputs settle within sixteen cycles after reset.
// RULE9: Device reset clears the three latches.
// RULE10: Host resets after power-up for buffers.
// RULE11: Transmit clock select low: capture on clock.
// RULE12: Receive clock select low: elasticity buffer on.
// RULE13: Buffer inserts or deletes framing characters.
// RULE14: Insert K28.5 right after a framing character.
// RULE15: Delete a detected framing character when full. The code deletes once fill exceeds HI_MARK, before the buffer is full.
// RULE16: Decoder mode low passes raw characters.
// RULE17: Host holds device reset over a clock edge.
module xcvr_dev_ctl
   import xcvr_ctl_pkg::*;
#(
   parameter int DEPTH   = 8,
   parameter int NOMINAL = 4,
   parameter int HI_MARK = 6,
   parameter int LO_MARK = 2,
   parameter int OE_W    = 8,
   parameter int RXL_W   = 4,
   parameter int BIST_W  = 2
) (
   // Clock and resets
   input  wire logic              i_ref_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_device_reset_n,
   // AXI4-Lite slave
   input  wire logic [7:0]        i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [7:0]        i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic                   o_irq,
   // Parallel transmit interface
   input  wire logic              i_tx_valid,
   input  wire logic [7:0]        i_tx_data_in,
   input  wire logic [1:0]        i_tx_control_in,
   input  wire logic              i_tx_parity_in,
   output logic                   o_tx_parity_err,
   // Recovered receive characters
   input  wire logic              i_rec_valid,
   input  wire logic [9:0]        i_rec_raw,
   input  wire logic [7:0]        i_rec_byte,
   input  wire logic [2:0]        i_rec_status,
   input  wire logic              i_rec_frame,
   // Parallel receive interface
   output logic                   o_rx_valid,
   output logic [7:0]             o_rx_data_out,
   output logic [2:0]             o_rx_status_out,
   output logic                   o_rx_parity_out,
   output logic                   o_rx_parity_oe,
   // Link configuration
   output logic [1:0]             o_pll_range,
   // Latches
   input  wire logic              i_self_test_latch_enable,
   input  wire logic [BIST_W-1:0] i_self_test_ctl,
   output logic [BIST_W-1:0]      o_self_test_ctl,
   input  wire logic              i_output_enable_latch_enable,
   input  wire logic [OE_W-1:0]   i_out_enable,
   output logic [OE_W-1:0]        o_out_enable,
   input  wire logic              i_rx_channel_latch_enable,
   input  wire logic [RXL_W-1:0]  i_rx_channel_ctl,
   output logic [RXL_W-1:0]       o_rx_channel_ctl
);

   localparam int PW = $clog2(DEPTH);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic              dev_rst;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [IRQ_W-1:0]  irq_st_ff;
   logic [IRQ_W-1:0]  irq_en_ff;
   logic [IRQ_W-1:0]  nxt_irq_st;
   logic [IRQ_W-1:0]  irq_ev;
   logic [IRQ_W-1:0]  irq_clr;
   logic              aw_hold_ff;
   logic [7:0]        awaddr_ff;
   logic              w_hold_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   logic              wr_fire;
   logic [1:0]        par_sel;
   logic [1:0]        rate_sel;
   logic              half_rate;
   logic [1:0]        txm_sel;
   logic [1:0]        dec_sel;
   logic              txck_sel;
   logic              rxck_sel;
   logic              bad_cfg;
   logic              bad_cfg_ff;
   logic [3:0]        settle_ff;
   logic              ready;
   logic              tx_take;
   logic              tx_odd;
   logic              tx_err;
   logic              tx_err_ff;
   logic [21:0]       mem_ff [DEPTH];
   logic [PW:0]       wr_ptr_ff;
   logic [PW:0]       rd_ptr_ff;
   logic [PW:0]       fill;
   logic              eb_on;
   logic              do_del;
   logic              do_wr;
   logic              do_rd;
   logic              insert_ff;
   logic [21:0]       head;
   logic              src_vld;
   logic [21:0]       src;
   logic [7:0]        out_d;
   logic [2:0]        out_s;
   logic              out_p;
   logic              rx_valid_ff;
   logic [7:0]        rx_data_ff;
   logic [2:0]        rx_status_ff;
   logic              rx_par_ff;
   logic              rx_oe_ff;
   logic [BIST_W-1:0] bist_ff;
   logic [OE_W-1:0]   oe_ff;
   logic [RXL_W-1:0]  rxl_ff;

   // Device reset sampled on the reference clock
   assign dev_rst   = i_sys_rst | ~i_device_reset_n;             // [RULE7]

   assign par_sel   = ctrl_ff[CTRL_PAR_LSB +: 2];
   assign rate_sel  = ctrl_ff[CTRL_RATE_LSB +: 2];
   assign half_rate = ctrl_ff[CTRL_HALF_BIT];
   assign txm_sel   = ctrl_ff[CTRL_TXM_LSB +: 2];
   assign dec_sel   = ctrl_ff[CTRL_DEC_LSB +: 2];
   assign txck_sel  = ctrl_ff[CTRL_TXCK_BIT];
   assign rxck_sel  = ctrl_ff[CTRL_RXCK_BIT];

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   assign o_awready = ~aw_hold_ff & ~bvalid_ff;
   assign o_wready  = ~w_hold_ff & ~bvalid_ff;
   assign o_arready = ~rvalid_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;
   assign wr_fire   = aw_hold_ff & w_hold_ff & ~bvalid_ff;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff  <= 8'h00;
      end else if (i_awvalid && o_awready) begin
         aw_hold_ff <= 1'b1;
         awaddr_ff  <= i_awaddr;
      end else if (wr_fire) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         w_hold_ff <= 1'b0;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end else if (i_wvalid && o_wready) begin
         w_hold_ff <= 1'b1;
         wdata_ff  <= i_wdata;
         wstrb_ff  <= i_wstrb;
      end else if (wr_fire) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         unique case (awaddr_ff)
            CTRL_OFS, IRQ_EN_OFS, IRQ_CLR_OFS: bresp_ff <= RESP_OKAY;
            default:                           bresp_ff <= RESP_SLVERR;
         endcase
      end else if (i_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_fire && awaddr_ff == CTRL_OFS) begin
         if (wstrb_ff[0]) ctrl_ff[7:0] <= wdata_ff[7:0];
         if (wstrb_ff[1]) ctrl_ff[CTRL_W-1:8] <= wdata_ff[CTRL_W-1:8];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         irq_en_ff <= IRQ_RST;
      end else if (wr_fire && awaddr_ff == IRQ_EN_OFS && wstrb_ff[0]) begin
         irq_en_ff <= wdata_ff[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= RESP_OKAY;
         unique case (i_araddr)
            CTRL_OFS:    rdata_ff <= {21'h0, ctrl_ff};
            STATUS_OFS:  rdata_ff <= {24'h0, fill, bad_cfg, ready,
                                      o_pll_range};
            IRQ_ST_OFS:  rdata_ff <= {28'h0, irq_st_ff};
            IRQ_EN_OFS:  rdata_ff <= {28'h0, irq_en_ff};
            IRQ_CLR_OFS: rdata_ff <= 32'h0000_0000;
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (i_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   assign irq_clr = (wr_fire && awaddr_ff == IRQ_CLR_OFS && wstrb_ff[0])
                    ? wdata_ff[IRQ_W-1:0] : IRQ_RST;
   assign irq_ev[IRQ_PAR_ERR] = tx_err;
   assign irq_ev[IRQ_INSERT]  = eb_on & do_rd & head[21] &
                                (fill < (PW+1)'(LO_MARK)) & ~insert_ff;
   assign irq_ev[IRQ_DELETE]  = do_del;
   assign irq_ev[IRQ_BAD_CFG] = bad_cfg & ~bad_cfg_ff;
   // Set wins over clear
   assign nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;
   assign o_irq      = |(irq_st_ff & irq_en_ff);

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) irq_st_ff <= IRQ_RST;
      else           irq_st_ff <= nxt_irq_st;
   end

   // ------------------------------------------------------------
   // Rate range and configuration check
   // ------------------------------------------------------------
   assign o_pll_range = rate_sel;                               // [RULE5]
   assign bad_cfg     = (rate_sel == LVL_LOW) & half_rate;      // [RULE6]

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) bad_cfg_ff <= 1'b0;
      else           bad_cfg_ff <= bad_cfg;
   end

   // ------------------------------------------------------------
   // Settling after device reset
   // ------------------------------------------------------------
   assign ready = (settle_ff == SETTLE_CYCLES);

   always_ff @(posedge i_ref_clk) begin
      if (dev_rst)     settle_ff <= 4'h0;                       // [RULE8]
      else if (!ready) settle_ff <= settle_ff + 4'h1;
   end

   // ------------------------------------------------------------
   // Transmit parity check
   // ------------------------------------------------------------
   assign tx_take = i_tx_valid & ~txck_sel;                     // [RULE11]
   always_comb begin
      tx_odd = 1'b1;
      unique case (par_sel)
         LVL_LOW: tx_odd = 1'b1;                                // [RULE1]
         LVL_MID: tx_odd = (txm_sel == LVL_LOW)
                  ? ^{i_tx_data_in, i_tx_control_in, i_tx_parity_in}
                  : ^{i_tx_data_in, i_tx_parity_in};            // [RULE2] [RULE3]
         default: tx_odd =
                  ^{i_tx_data_in, i_tx_control_in, i_tx_parity_in}; // [RULE4]
      endcase
   end
   assign tx_err = tx_take & ~tx_odd & ~dev_rst;
   assign o_tx_parity_err = tx_err_ff;

   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) tx_err_ff <= 1'b0;
      else         tx_err_ff <= tx_err;
   end

   // ------------------------------------------------------------
   // Elasticity buffer
   // ------------------------------------------------------------
   assign eb_on  = ~rxck_sel;                                   // [RULE12]
   assign fill   = wr_ptr_ff - rd_ptr_ff;
   assign head   = mem_ff[rd_ptr_ff[PW-1:0]];
   assign do_del = eb_on & i_rec_valid & i_rec_frame &
                   (fill > (PW+1)'(HI_MARK));                   // [RULE13] [RULE15]
   assign do_wr  = eb_on & i_rec_valid & ~do_del &
                   (fill != (PW+1)'(DEPTH)) & ~dev_rst;
   assign do_rd  = eb_on & ready & (fill != '0) & ~insert_ff;

   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= {1'b1, K28_5_STATUS, K28_5_RAW, K28_5_BYTE};
         end
      end else if (do_wr) begin
         mem_ff[wr_ptr_ff[PW-1:0]] <= {i_rec_frame, i_rec_status,
                                       i_rec_raw, i_rec_byte};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) wr_ptr_ff <= (PW+1)'(NOMINAL);               // [RULE7]
      else if (do_wr) wr_ptr_ff <= wr_ptr_ff + 1'b1;
   end

   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) rd_ptr_ff <= '0;                             // [RULE7]
      else if (do_rd) rd_ptr_ff <= rd_ptr_ff + 1'b1;
   end

   // Extra K28.5 follows the framing character just read
   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) insert_ff <= 1'b0;
      else         insert_ff <= irq_ev[IRQ_INSERT];             // [RULE14]
   end

   // ------------------------------------------------------------
   // Receive output formatting
   // ------------------------------------------------------------
   always_comb begin
      src_vld = eb_on ? (do_rd | insert_ff) : i_rec_valid;
      src     = {i_rec_frame, i_rec_status, i_rec_raw, i_rec_byte};
      if (eb_on && insert_ff) begin
         src = {1'b1, K28_5_STATUS, K28_5_RAW, K28_5_BYTE};     // [RULE14]
      end else if (eb_on) begin
         src = head;
      end
      if (dec_sel == LVL_LOW) begin
         out_d = src[15:8];                                     // [RULE16]
         out_s = {1'b0, src[17:16]};
      end else begin
         out_d = src[7:0];
         out_s = src[20:18];
      end
      unique case (par_sel)
         LVL_LOW: out_p = 1'b0;
         LVL_MID: out_p = (dec_sel == LVL_LOW)
                  ? ~^{out_d, out_s[1:0]} : ~^out_d;             // [RULE2] [RULE3]
         default: out_p = ~^{out_d, out_s};                      // [RULE4]
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) begin
         rx_valid_ff  <= 1'b0;
         rx_data_ff   <= 8'h00;
         rx_status_ff <= 3'h0;
         rx_par_ff    <= 1'b0;
         rx_oe_ff     <= 1'b0;
      end else begin
         rx_valid_ff  <= src_vld & ready;                       // [RULE8]
         rx_data_ff   <= src_vld ? out_d : rx_data_ff;
         rx_status_ff <= src_vld ? out_s : rx_status_ff;
         rx_par_ff    <= src_vld ? out_p : rx_par_ff;
         rx_oe_ff     <= (par_sel != LVL_LOW);                  // [RULE1]
      end
   end
   assign o_rx_valid      = rx_valid_ff;
   assign o_rx_data_out   = rx_data_ff;
   assign o_rx_status_out = rx_status_ff;
   assign o_rx_parity_out = rx_par_ff;
   assign o_rx_parity_oe  = rx_oe_ff;

   // ------------------------------------------------------------
   // Transparent latches, cleared by device reset
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) bist_ff <= '0;                               // [RULE9]
      else if (i_self_test_latch_enable) bist_ff <= i_self_test_ctl;
   end
   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) oe_ff <= '0;                                 // [RULE9]
      else if (i_output_enable_latch_enable) oe_ff <= i_out_enable;
   end
   always_ff @(posedge i_ref_clk) begin
      if (dev_rst) rxl_ff <= '0;                                // [RULE9]
      else if (i_rx_channel_latch_enable) rxl_ff <= i_rx_channel_ctl;
   end
   assign o_self_test_ctl  = (i_self_test_latch_enable && !dev_rst)
                             ? i_self_test_ctl : bist_ff;
   assign o_out_enable     = (i_output_enable_latch_enable && !dev_rst)
                             ? i_out_enable : oe_ff;
   assign o_rx_channel_ctl = (i_rx_channel_latch_enable && !dev_rst)
                             ? i_rx_channel_ctl : rxl_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   parity_off_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (par_sel == LVL_LOW) |=> !o_rx_parity_oe && !o_tx_parity_err)
      else $error("parity active while disabled"); // [RULE1]
   rx_odd_a: assert property (@(posedge i_ref_clk) disable iff (dev_rst)
      (par_sel == LVL_HIGH && $past(par_sel) == LVL_HIGH && o_rx_valid) |->
      ^{o_rx_data_out, o_rx_status_out, o_rx_parity_out})
      else $error("receive parity not odd"); // [RULE4]
   tx_check_a: assert property (@(posedge i_ref_clk) disable iff (dev_rst)
      (tx_take && par_sel == LVL_MID && txm_sel != LVL_LOW &&
       !(^{i_tx_data_in, i_tx_parity_in})) |=> o_tx_parity_err)
      else $error("missed transmit parity error"); // [RULE2]
   tx_ctl_a: assert property (@(posedge i_ref_clk) disable iff (dev_rst)
      (tx_take && par_sel == LVL_MID && txm_sel == LVL_LOW &&
       ^{i_tx_data_in, i_tx_control_in, i_tx_parity_in}) |=>
      !o_tx_parity_err)
      else $error("false transmit parity error"); // [RULE3]
   range_map_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_pll_range == ctrl_ff[CTRL_RATE_LSB +: 2])
      else $error("pll range mismatch"); // [RULE5]
   ptr_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      $past(dev_rst) |-> fill == (PW+1)'(NOMINAL))
      else $error("pointers not at nominal offset"); // [RULE7]
   settle_time_a: assert property (@(posedge i_ref_clk) disable iff (dev_rst)
      $fell(dev_rst) |-> ##[0:15] ready)
      else $error("outputs not settled in time"); // [RULE8]
   latch_clr_a: assert property (@(posedge i_ref_clk)
      dev_rst |=> oe_ff == '0 && bist_ff == '0 && rxl_ff == '0)
      else $error("latch survived reset"); // [RULE9]
   ins_k285_a: assert property (@(posedge i_ref_clk) disable iff (dev_rst)
      (insert_ff && eb_on && dec_sel != LVL_LOW) |=>
      o_rx_data_out == K28_5_BYTE && $stable(rd_ptr_ff))
      else $error("inserted character is not K28.5"); // [RULE14]
   del_frame_a: assert property (@(posedge i_ref_clk) disable iff (dev_rst)
      do_del |=> wr_ptr_ff == $past(wr_ptr_ff))
      else $error("deleted character was stored"); // [RULE15]

endmodule

// ---- tb/xcvr_host_model.sv ----
`timescale 1ns/10ps
module xcvr_host_model (
   // Clock and requests
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_req,
   input  wire logic        i_send,
   input  wire logic [10:0] i_word,
   // Device side
   output logic             o_device_reset_n,
   output logic             o_tx_valid,
   output logic [10:0]      o_tx_word
);
   // Reset held low over whole edges while requested
   always_ff @(posedge i_ref_clk) begin
      o_device_reset_n <= !i_rst_req;
   end
   // Idle word lines toggle so stale data never looks valid
   always_ff @(posedge i_ref_clk) begin
      o_tx_valid <= i_send;
      if (i_rst_req) begin
         o_tx_word <= 11'h000;
      end else if (i_send) begin
         o_tx_word <= i_word;
      end else begin
         o_tx_word <= ~o_tx_word;
      end
   end
endmodule

// ---- tb/transceiver_device_control_tb.sv ----
`timescale 1ns/10ps
module transceiver_device_control_tb;
   import xcvr_ctl_pkg::*;
   typedef struct packed {
      logic [1:0]  sel;
      logic [1:0]  rate;
      logic [1:0]  txm;
      logic [10:0] word;
      logic        err;
   } row_t;
   // Word packs {parity, control, data}; low rate never with half rate
   row_t rows [7] = '{
      '{LVL_LOW, 2'h0, LVL_LOW, 11'h000, 1'b0},
      '{LVL_MID, 2'h1, LVL_MID, 11'h101, 1'b0},
      '{LVL_MID, 2'h1, LVL_MID, 11'h401, 1'b1},
      '{LVL_MID, 2'h2, LVL_LOW, 11'h101, 1'b1},
      '{LVL_MID, 2'h2, LVL_LOW, 11'h501, 1'b0},
      '{LVL_HIGH, 2'h2, LVL_MID, 11'h603, 1'b1},
      '{LVL_HIGH, 2'h1, LVL_LOW, 11'h703, 1'b0}};
   logic clk, sys_rst, rst_req, send, rst_n, txv, lat_le;
   logic [10:0] word, txw;
   logic [7:0] awaddr, araddr, rxd, oen;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, rxl;
   logic [2:0] rxs;
   logic awvalid, wvalid, bready, arvalid, rready, awrdy, wrdy, bvld;
   logic arrdy, rvld, irq, perr, rxv, poe, rec_v, rec_f;
   logic [1:0] bresp, rresp, pll, bst;
   int n_mismatch = 0;
   int compares = 0;
   int n;
   xcvr_host_model i_host (.i_ref_clk(clk), .i_rst_req(rst_req),
      .i_send(send), .i_word(word), .o_device_reset_n(rst_n),
      .o_tx_valid(txv), .o_tx_word(txw));
   xcvr_dev_ctl i_dut (.i_ref_clk(clk), .i_sys_rst(sys_rst),
      .i_device_reset_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awrdy), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bvld),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvld),
      .i_rready(rready), .o_irq(irq), .i_tx_valid(txv),
      .i_tx_data_in(txw[7:0]), .i_tx_control_in(txw[9:8]),
      .i_tx_parity_in(txw[10]), .o_tx_parity_err(perr),
      .i_rec_valid(rec_v), .i_rec_raw(10'h000), .i_rec_byte(txw[7:0]),
      .i_rec_status(3'h0), .i_rec_frame(rec_f), .o_rx_valid(rxv),
      .o_rx_data_out(rxd), .o_rx_status_out(rxs), .o_rx_parity_out(),
      .o_rx_parity_oe(poe), .o_pll_range(pll),
      .i_self_test_latch_enable(lat_le), .i_self_test_ctl(2'h3),
      .o_self_test_ctl(bst), .i_output_enable_latch_enable(lat_le),
      .i_out_enable(8'hff), .o_out_enable(oen),
      .i_rx_channel_latch_enable(lat_le), .i_rx_channel_ctl(4'hf),
      .o_rx_channel_ctl(rxl));
   task automatic final_report;
      if (n_mismatch == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awrdy) awvalid <= 1'b0;
         if (wvalid && wrdy) wvalid <= 1'b0;
         if (bvld) begin
            bready <= 1'b0;
            chk(bresp, er);
            break;
         end
      end
      if (n == 50) begin
         n_mismatch++;
         final_report();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arrdy) arvalid <= 1'b0;
         if (rvld) begin
            rready <= 1'b0;
            chk(rresp, er);
            chk(rdata & m, exp);
            break;
         end
      end
      if (n == 50) begin
         n_mismatch++;
         final_report();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {sys_rst, rst_req, send, word, lat_le, rec_v, rec_f} =
         {1'b1, 1'b1, 15'h0};
      {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rst_req <= 1'b0;
      rd(CTRL_OFS, 32'(CTRL_RST), 32'hffffffff, RESP_OKAY);
      rd(IRQ_EN_OFS, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(STATUS_OFS, 32'h0000000f, RESP_SLVERR);
      // Ordinary parity and rate cases
      foreach (rows[i]) begin
         wr(CTRL_OFS, 32'(rows[i].sel) << CTRL_PAR_LSB |
            32'(rows[i].rate) << CTRL_RATE_LSB |
            32'(rows[i].txm) << CTRL_TXM_LSB, RESP_OKAY);
         @(posedge clk);
         send <= 1'b1;
         word <= rows[i].word;
         @(posedge clk);
         send <= 1'b0;
         @(posedge clk);
         #1;
         chk(perr, rows[i].err);
         chk(poe, rows[i].sel != LVL_LOW);
         chk(pll, rows[i].rate);
      end
      // Interrupt raise, mask, clear
      rd(IRQ_ST_OFS, 32'h1, 32'h1, RESP_OKAY);
      wr(IRQ_EN_OFS, 32'h1, RESP_OKAY);
      #1 chk(irq, 1'b1);
      wr(IRQ_EN_OFS, 32'h0, RESP_OKAY);
      #1 chk(irq, 1'b0);
      wr(IRQ_CLR_OFS, 32'h1, RESP_OKAY);
      rd(IRQ_ST_OFS, 32'h0, 32'h1, RESP_OKAY);
      // Latch capture, then device reset
      wr(CTRL_OFS, 32'h0, RESP_OKAY);
      @(posedge clk);
      lat_le <= 1'b1;
      @(posedge clk);
      lat_le <= 1'b0;
      rst_req <= 1'b1;
      @(posedge clk);
      #1 chk({bst, rxl, oen}, 14'h3fff);
      repeat (2) @(posedge clk);
      #1 chk({bst, rxl, oen}, 14'h0000);
      rst_req <= 1'b0;
      // Framing characters arrive while settling: buffer fills past HI_MARK
      {rec_v, rec_f} <= 2'h3;
      for (n = 0; n < 17 && rxv !== 1'b1; n++) @(posedge clk) #1;
      {rec_v, rec_f} <= 2'h0;
      chk(n < 17, 1'b1);
      chk(rxd, K28_5_RAW[7:0]);
      chk(rxs, {1'b0, K28_5_RAW[9:8]});
      repeat (12) @(posedge clk);
      rd(IRQ_ST_OFS, 32'h6, 32'h6, RESP_OKAY);
      final_report();
   end
endmodule
